// file: hw/ppm_port.sv
// Parallel master/slave port with mode register, wait states and APB access
//
// Contract
// RULE1: Sixteen-bit mode register clears on reset; bit 15 is read-only busy flag.
// RULE2: Interrupt select: none, end of every cycle, or buffer 3 / address 3 access.
// RULE3: Address holds, steps up or down per cycle; slave buffers auto-increment option.
// RULE4: Wide bit: one data access makes two byte transfers, else one byte.
// RULE5: Setup wait of 1 to 4 cycles before strobe; address phase equally long.
// RULE6: Strobe wait adds 0 to 15 cycles; strobe lasts one cycle at code zero.
// RULE7: Strobe code zero ignores setup and hold; hold otherwise 1 to 4 cycles.
// RULE8: Port mode field picks legacy slave, buffered slave, master 2 or master 1.
`timescale 1ns/100ps
`include "ppm_params.svh"
module ppm_port (
   input  wire logic        pclk,              // System clock, 200 MHz
   input  wire logic        presetn,           // Async reset, active low
   input  wire logic [11:0] paddr,             // APB address
   input  wire logic        psel,              // APB select
   input  wire logic        penable,           // APB enable
   input  wire logic        pwrite,            // APB direction
   input  wire logic [31:0] pwdata,            // APB write data
   output logic      [31:0] prdata,            // APB read data
   output logic             pready,            // APB ready
   output logic             pslverr,           // APB error on unmapped address
   output logic             irq,               // Level interrupt
   output logic      [10:0] pm_addr,           // Port address pins
   output logic             pm_addr_oe,        // Address pins driven
   output logic             pm_ale,            // Address phase strobe
   output logic             pm_cs,             // Chip select
   output logic             pm_rd,             // Read strobe, or direction in master 1
   output logic             pm_wr,             // Write strobe, or enable in master 1
   output logic             pm_be,             // Byte enable strobe
   output logic             pm_ctl_oe,         // Control pins driven
   output logic      [7:0]  pm_data_o,         // Data pins out
   output logic             pm_data_oe,        // Data pins driven
   input  wire logic [7:0]  pm_data_i,         // Data pins in
   input  wire logic        slave_cs_n,        // External chip select in slave mode
   input  wire logic        slave_rd_n,        // External read strobe in slave mode
   input  wire logic        slave_wr_n,        // External write strobe in slave mode
   input  wire logic [1:0]  port_address_low   // External buffer address in slave mode
);
   ppm_pkg::ppm_state_t st_r, st_nxt;
   logic [14:0] mode_r;
   logic [15:0] tx_r, rx_r;
   logic [1:0]  stat_r, mask_r, ptr_r;
   logic        go_r, dir_rd_r, lane_r;
   logic [7:0]  tx_buf [4];
   logic [7:0]  rx_buf [4];
   logic [31:0] prdata_r;
   logic [12:0] sync1_r, sync2_r;
   logic        rd_d_r, wr_d_r;
   logic [7:0]  data_o_r;
   logic        data_oe_r;
   logic [7:0]  cyc_r;

   // Field decode
   wire ppm_pkg::ppm_irq_t  irq_request_select = ppm_pkg::ppm_irq_t'(mode_r[`PPM_IRQ_MSB:`PPM_IRQ_LSB]);
   wire ppm_pkg::ppm_step_t address_step_select = ppm_pkg::ppm_step_t'(mode_r[`PPM_STEP_MSB:`PPM_STEP_LSB]);
   wire ppm_pkg::ppm_port_t port_mode = ppm_pkg::ppm_port_t'(mode_r[`PPM_PORT_MSB:`PPM_PORT_LSB]);
   wire       wide_transfer_select = mode_r[`PPM_WIDE_BIT];
   wire [1:0] setup_wait_cycles    = mode_r[`PPM_SETUP_MSB:`PPM_SETUP_LSB];
   wire [3:0] strobe_wait_cycles   = mode_r[`PPM_STROBE_MSB:`PPM_STROBE_LSB];
   wire [1:0] hold_wait_cycles     = mode_r[`PPM_HOLD_MSB:`PPM_HOLD_LSB];
   wire       master = (port_mode == ppm_pkg::PPM_MASTER2) || (port_mode == ppm_pkg::PPM_MASTER1);
   wire       busy   = master && (go_r || st_r != ppm_pkg::PPM_IDLE);
   wire       no_strobe_wait = (strobe_wait_cycles == 4'h0);
   wire [4:0] setup_len  = ppm_pkg::ppm_wait_len(setup_wait_cycles, no_strobe_wait);  // RULE5 RULE7
   wire [4:0] hold_len   = ppm_pkg::ppm_wait_len(hold_wait_cycles, no_strobe_wait);   // RULE7
   wire [4:0] strobe_len = {1'b0, strobe_wait_cycles} + 5'h01;                       // RULE6

   // APB decode
   wire       setup_ph = psel && !penable;
   wire       acc      = psel && penable;
   wire       wr_acc   = acc && pwrite;
   wire       rd_acc   = acc && !pwrite;
   wire       hit_mode = (paddr == `PPM_OFS_MODE);
   wire       hit_data = (paddr == `PPM_OFS_DATA);
   wire       hit_addr = (paddr == `PPM_OFS_ADDR);
   wire       hit_stat = (paddr == `PPM_OFS_STAT);
   wire       hit_mask = (paddr == `PPM_OFS_MASK);
   wire       hit_buf  = ({paddr[11:4], 4'h0} == `PPM_OFS_BUF) && (paddr[1:0] == 2'h0);
   wire [1:0] bidx     = paddr[3:2];
   wire       mapped   = hit_mode || hit_data || hit_addr || hit_stat || hit_mask || hit_buf;
   wire       start_wr = wr_acc && hit_data && master && !busy;
   wire       start_rd = rd_acc && hit_data && master && !busy;
   wire [31:0] rd_mux  = hit_mode ? {16'h0000, busy, mode_r} :                        // RULE1
                         hit_data ? {16'h0000, rx_r} :
                         hit_addr ? {21'h000000, pm_addr} :
                         hit_stat ? {30'h00000000, stat_r} :
                         hit_mask ? {30'h00000000, mask_r} :
                         hit_buf  ? {24'h000000, rx_buf[bidx]} : 32'h00000000;

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
   assign prdata  = prdata_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (setup_ph) begin
         prdata_r <= rd_mux;
      end
   end

   // Mode register; refused while a master transfer runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= `PPM_MODE_RST;                                                     // RULE1
      end else if (wr_acc && hit_mode && !busy) begin
         mode_r <= pwdata[14:0];                                                      // RULE1
      end
   end

   // Sequencer
   logic       tick, done, load;
   logic [4:0] len;
   wire        two_bytes = wide_transfer_select && !lane_r;                           // RULE4
   wire        finish    = (st_r == ppm_pkg::PPM_HOLD) && done && !two_bytes;
   wire        capture   = (st_r == ppm_pkg::PPM_STROBE) && done && dir_rd_r;

   always_comb begin
      st_nxt = st_r;
      load   = 1'b0;
      len    = setup_len;
      unique case (st_r)
         ppm_pkg::PPM_IDLE: begin
            if (tick && go_r) begin
               st_nxt = ppm_pkg::PPM_SETUP;                                           // RULE5
               load   = 1'b1;
            end
         end
         ppm_pkg::PPM_SETUP: begin
            if (done) begin
               st_nxt = ppm_pkg::PPM_STROBE;                                          // RULE6
               load   = 1'b1;
               len    = strobe_len;
            end
         end
         ppm_pkg::PPM_STROBE: begin
            if (done) begin
               st_nxt = ppm_pkg::PPM_HOLD;                                            // RULE7
               load   = 1'b1;
               len    = hold_len;
            end
         end
         ppm_pkg::PPM_HOLD: begin
            if (done) begin
               st_nxt = two_bytes ? ppm_pkg::PPM_SETUP : ppm_pkg::PPM_IDLE;           // RULE4
               load   = two_bytes;
            end
         end
      endcase
   end

   ppm_wait_timer u_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (load),
      .len     (len),
      .tick    (tick),
      .done    (done)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r   <= ppm_pkg::PPM_IDLE;
         lane_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         lane_r <= (st_nxt == ppm_pkg::PPM_IDLE) ? 1'b0 : (st_r == ppm_pkg::PPM_HOLD && done) ? 1'b1 : lane_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_r     <= 1'b0;
         dir_rd_r <= 1'b0;
         tx_r     <= 16'h0000;
      end else if (start_wr || start_rd) begin
         go_r     <= 1'b1;
         dir_rd_r <= start_rd;
         tx_r     <= start_wr ? pwdata[15:0] : tx_r;
      end else if (st_r == ppm_pkg::PPM_IDLE && tick) begin
         go_r     <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_r <= 16'h0000;
      end else if (capture && lane_r) begin
         rx_r[15:8] <= sync2_r[7:0];                                                  // RULE4
      end else if (capture) begin
         rx_r[7:0] <= sync2_r[7:0];
      end
   end

   ppm_addr_unit u_addr (
      .pclk     (pclk),
      .presetn  (presetn),
      .wr_en    (wr_acc && hit_addr),
      .wr_data  (pwdata[10:0]),
      .step_en  (finish),                                                             // RULE3
      .step_sel (address_step_select),
      .addr     (pm_addr)
   );

   // Slave side: pins pass two flops before use
   wire       cs_s = sync2_r[12];
   wire       rd_s = sync2_r[11];
   wire       wr_s = sync2_r[10];
   wire [1:0] al_s = sync2_r[9:8];
   wire       slv_rd_end = !master && !cs_s && rd_s && !rd_d_r;
   wire       slv_wr_end = !master && !cs_s && wr_s && !wr_d_r;
   wire       auto_ptr = (address_step_select == ppm_pkg::PPM_STEP_BUF);
   wire [1:0] idx = (port_mode == ppm_pkg::PPM_LEGACY_SLV) ? 2'h0 : auto_ptr ? ptr_r : al_s;  // RULE8 RULE3

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= `PPM_SYNC_RST;
         sync2_r <= `PPM_SYNC_RST;
         rd_d_r  <= 1'b1;
         wr_d_r  <= 1'b1;
      end else begin
         sync1_r <= {slave_cs_n, slave_rd_n, slave_wr_n, port_address_low, pm_data_i};
         sync2_r <= sync1_r;
         rd_d_r  <= rd_s;
         wr_d_r  <= wr_s;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptr_r <= 2'h0;
      end else if (port_mode == ppm_pkg::PPM_BUF_SLV && auto_ptr && (slv_rd_end || slv_wr_end)) begin
         ptr_r <= ptr_r + 2'h1;                                                       // RULE3
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            tx_buf[i] <= 8'h00;
            rx_buf[i] <= 8'h00;
         end
      end else begin
         if (wr_acc && hit_buf) begin
            tx_buf[bidx] <= pwdata[7:0];
         end
         if (slv_wr_end) begin
            rx_buf[idx] <= sync2_r[7:0];
         end
      end
   end

   // Pins
   wire active = (st_r != ppm_pkg::PPM_IDLE);
   wire strobe = (st_r == ppm_pkg::PPM_STROBE);

   assign pm_addr_oe = master;                                                        // RULE8
   assign pm_ctl_oe  = master;
   assign pm_cs      = active;
   assign pm_ale     = (st_r == ppm_pkg::PPM_SETUP);                                  // RULE5
   assign pm_be      = strobe;
   assign pm_rd      = (port_mode == ppm_pkg::PPM_MASTER1) ? (active && dir_rd_r) : (strobe && dir_rd_r);
   assign pm_wr      = (port_mode == ppm_pkg::PPM_MASTER1) ? strobe : (strobe && !dir_rd_r);
   assign pm_data_o  = data_o_r;
   assign pm_data_oe = data_oe_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_o_r  <= 8'h00;
         data_oe_r <= 1'b0;
      end else if (master) begin
         data_o_r  <= lane_r ? tx_r[15:8] : tx_r[7:0];
         data_oe_r <= active && !dir_rd_r;
      end else begin
         data_o_r  <= tx_buf[idx];
         data_oe_r <= !cs_s && !rd_s;
      end
   end

   // Events and interrupt; a new event wins over the read clear
   wire buf3_sel = (irq_request_select == ppm_pkg::PPM_IRQ_BUF3) || (irq_request_select == ppm_pkg::PPM_IRQ_BUF3B);
   wire ev_xfer  = (irq_request_select == ppm_pkg::PPM_IRQ_EACH) && (finish || slv_rd_end || slv_wr_end);  // RULE2
   wire ev_buf3  = buf3_sel && ((finish && pm_addr[1:0] == `PPM_BUF3_IDX) ||
                   ((slv_rd_end || slv_wr_end) && idx == `PPM_BUF3_IDX));                      // RULE2
   wire [1:0] ev = {ev_buf3, ev_xfer};
   wire [1:0] clr = (rd_acc && hit_stat) ? prdata_r[1:0] : 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 2'h0;
         mask_r <= 2'h0;
      end else begin
         stat_r <= (stat_r & ~clr) | ev;
         mask_r <= (wr_acc && hit_mask) ? pwdata[1:0] : mask_r;
      end
   end

   assign irq = |(stat_r & mask_r);

   // Cycle count inside the current phase, for the checks below
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_r <= 8'h00;
      end else begin
         cyc_r <= (st_nxt != st_r) ? 8'h01 : cyc_r + 8'h01;
      end
   end

   property p_busy_read;
      @(posedge pclk) disable iff (!presetn)
         setup_ph && hit_mode && st_r != ppm_pkg::PPM_IDLE |=> prdata_r[`PPM_BUSY_BIT];
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy not shown during a transfer"); // RULE1

   property p_irq_off;
      @(posedge pclk) disable iff (!presetn) (irq_request_select == ppm_pkg::PPM_IRQ_OFF) |-> ev == 2'h0;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("event raised with interrupts off"); // RULE2

   property p_step_up;
      @(posedge pclk) disable iff (!presetn)
         finish && address_step_select == ppm_pkg::PPM_STEP_UP && !(wr_acc && hit_addr)
         |=> pm_addr == $past(pm_addr) + 11'h001;
   endproperty
   a_step_up: assert property (p_step_up) else $error("address did not step up"); // RULE3

   property p_wide;
      @(posedge pclk) disable iff (!presetn) finish |-> lane_r == wide_transfer_select;
   endproperty
   a_wide: assert property (p_wide) else $error("wrong byte count per access"); // RULE4

   property p_setup_len;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ppm_pkg::PPM_SETUP && st_nxt != st_r) |-> int'(cyc_r) == int'(setup_len) * `PPM_TCY_CLKS;
   endproperty
   a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong"); // RULE5

   property p_strobe_len;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ppm_pkg::PPM_STROBE && st_nxt != st_r) |-> int'(cyc_r) == int'(strobe_len) * `PPM_TCY_CLKS;
   endproperty
   a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong"); // RULE6

   property p_hold_len;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ppm_pkg::PPM_HOLD && st_nxt != st_r) |->
         int'(cyc_r) == (no_strobe_wait ? 1 : int'(hold_wait_cycles) + 1) * `PPM_TCY_CLKS;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold length wrong"); // RULE7

   property p_slave_pins;
      @(posedge pclk) disable iff (!presetn) !master |-> !pm_ctl_oe && !pm_addr_oe && !pm_cs;
   endproperty
   a_slave_pins: assert property (p_slave_pins) else $error("master pins driven in slave mode"); // RULE8
endmodule : ppm_port

// file: hw/ppm_params.svh
// Constants for the parallel port mode block: offsets, fields, resets, timing
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH
`define PPM_CLK_NS        5
`define PPM_TCY_NS        20
`define PPM_TCY_CLKS      (`PPM_TCY_NS / `PPM_CLK_NS)
`define PPM_OFS_MODE      12'h000
`define PPM_OFS_DATA      12'h004
`define PPM_OFS_ADDR      12'h008
`define PPM_OFS_STAT      12'h00c
`define PPM_OFS_MASK      12'h010
`define PPM_OFS_BUF       12'h020
`define PPM_MODE_RST      15'h0000
`define PPM_BUSY_BIT      15
`define PPM_IRQ_MSB       14
`define PPM_IRQ_LSB       13
`define PPM_STEP_MSB      12
`define PPM_STEP_LSB      11
`define PPM_WIDE_BIT      10
`define PPM_PORT_MSB      9
`define PPM_PORT_LSB      8
`define PPM_SETUP_MSB     7
`define PPM_SETUP_LSB     6
`define PPM_STROBE_MSB    5
`define PPM_STROBE_LSB    2
`define PPM_HOLD_MSB      1
`define PPM_HOLD_LSB      0
`define PPM_EV_XFER       0
`define PPM_EV_BUF3       1
`define PPM_SYNC_RST      13'h1c00
`define PPM_BUF3_IDX      2'h3
`endif

// file: hw/ppm_pkg.sv
// Types and helper functions of the parallel port mode block
package ppm_pkg;
   typedef enum logic [1:0] {PPM_LEGACY_SLV, PPM_BUF_SLV, PPM_MASTER2, PPM_MASTER1} ppm_port_t;
   typedef enum logic [1:0] {PPM_IRQ_OFF, PPM_IRQ_EACH, PPM_IRQ_BUF3, PPM_IRQ_BUF3B} ppm_irq_t;
   typedef enum logic [1:0] {PPM_STEP_HOLD, PPM_STEP_UP, PPM_STEP_DOWN, PPM_STEP_BUF} ppm_step_t;
   typedef enum logic [1:0] {PPM_IDLE, PPM_SETUP, PPM_STROBE, PPM_HOLD} ppm_state_t;

   // Phase length in instruction cycles from a two-bit code
   function automatic logic [4:0] ppm_wait_len(input logic [1:0] code, input logic forced);
      ppm_wait_len = forced ? 5'h01 : ({3'h0, code} + 5'h01);
   endfunction : ppm_wait_len
endpackage : ppm_pkg

// file: hw/ppm_wait_timer.sv
// Instruction-cycle divider and wait-state phase counter
`timescale 1ns/100ps
`include "ppm_params.svh"
module ppm_wait_timer (
   input  wire logic       pclk,     // System clock
   input  wire logic       presetn,  // Async reset, active low
   input  wire logic       load,     // Start a phase, only on a tick
   input  wire logic [4:0] len,      // Phase length in instruction cycles
   output logic            tick,     // One-cycle instruction-cycle enable
   output logic            done      // Last tick of the running phase
);
   localparam logic [7:0] DIV_MAX = 8'(`PPM_TCY_CLKS - 1);

   logic [7:0] div_r;
   logic [4:0] cnt_r;

   assign tick = (div_r == DIV_MAX);
   assign done = tick && (cnt_r == 5'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 8'h00;
      end else begin
         div_r <= tick ? 8'h00 : div_r + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 5'h00;
      end else if (load) begin
         cnt_r <= len;
      end else if (tick && cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule : ppm_wait_timer

// file: hw/ppm_addr_unit.sv
// Port address register with automatic step after each cycle
`timescale 1ns/100ps
module ppm_addr_unit (
   input  wire logic              pclk,      // System clock
   input  wire logic              presetn,   // Async reset, active low
   input  wire logic              wr_en,     // Software write of the address
   input  wire logic [10:0]       wr_data,   // Address written by software
   input  wire logic              step_en,   // End of a read/write cycle
   input  ppm_pkg::ppm_step_t     step_sel,  // Step mode
   output logic      [10:0]       addr       // Current port address
);
   logic [10:0] addr_nxt;

   assign addr_nxt = wr_en ? wr_data :
                     (step_en && step_sel == ppm_pkg::PPM_STEP_UP)   ? addr + 11'h001 :
                     (step_en && step_sel == ppm_pkg::PPM_STEP_DOWN) ? addr - 11'h001 : addr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr <= 11'h000;
      end else begin
         addr <= addr_nxt;
      end
   end
endmodule : ppm_addr_unit

// file: test/ppm_ext_dev.sv
// External byte-wide peripheral that answers the master port
`timescale 1ns/100ps
module ppm_ext_dev (
   input  wire logic       pclk,       // System clock
   input  wire logic       pm_cs,      // Chip select
   input  wire logic       pm_rd,      // Read strobe or direction
   input  wire logic       pm_be,      // Byte strobe phase
   input  wire logic       pm_wr,      // Write strobe or enable
   input  wire logic       pm_data_oe, // Port drives the data pins
   input  wire logic [7:0] pm_data_o,  // Data from the port
   output logic      [7:0] pm_data_i,  // Data to the port
   output logic      [7:0] n_rd        // Read bytes served
);
   logic [7:0] wq[$];
   logic [7:0] last_q, dat_d;
   logic       be_d, rd_d, wr_d;
   initial begin
      n_rd = 8'h00;
      last_q = 8'h00;
      be_d = 1'b0;
      wr_d = 1'b0;
   end
   // Released bus shows the inverse of the last byte, never a stale copy
   assign pm_data_i = (pm_cs && pm_rd) ? 8'hc0 + n_rd : ~last_q;
   always @(posedge pclk) begin
      be_d <= pm_be;
      rd_d <= pm_rd;
      wr_d <= pm_wr;
      // Undriven data pins show a marker byte
      dat_d <= pm_data_oe ? pm_data_o : 8'hee;
      if (pm_cs && pm_rd)
         last_q <= 8'hc0 + n_rd;
      if (be_d && !pm_be && rd_d)
         n_rd <= n_rd + 8'h01;
      if (wr_d && !pm_wr && !rd_d)
         wq.push_back(dat_d);
   end
endmodule : ppm_ext_dev

// file: test/test_ppm_port.sv
// Self-checking bench of the parallel port mode block
`timescale 1ns/100ps
`include "ppm_params.svh"
module test_ppm_port;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] pm_addr;
   logic        pm_addr_oe, pm_ale, pm_cs, pm_rd, pm_wr, pm_be, pm_ctl_oe, pm_data_oe;
   logic [7:0]  pm_data_o, pm_data_i, n_rd, b;
   logic        s_cs_n, s_rd_n;
   int          n_fail, n_checks, n_ale, n_str, n_hold;

   ppm_port dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .pm_addr(pm_addr), .pm_addr_oe(pm_addr_oe), .pm_ale(pm_ale), .pm_cs(pm_cs), .pm_rd(pm_rd),
      .pm_wr(pm_wr), .pm_be(pm_be), .pm_ctl_oe(pm_ctl_oe), .pm_data_o(pm_data_o),
      .pm_data_oe(pm_data_oe), .pm_data_i(pm_data_i), .slave_cs_n(s_cs_n), .slave_rd_n(s_rd_n),
      .slave_wr_n(1'b1), .port_address_low(2'h0));
   ppm_ext_dev ext_u (.pclk(pclk), .pm_cs(pm_cs), .pm_rd(pm_rd), .pm_be(pm_be), .pm_wr(pm_wr),
      .pm_data_oe(pm_data_oe),
      .pm_data_o(pm_data_o), .pm_data_i(pm_data_i), .n_rd(n_rd));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Phase lengths in clocks, measured at the pins
   always @(posedge pclk) begin
      if (pm_ale) n_ale++;
      if (pm_be) n_str++;
      if (pm_cs && !pm_ale && !pm_be) n_hold++;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Waits until chip select has stayed low for eight clocks
   task xfer_wait;
      int k, q;
      k = 0;
      q = 0;
      while (q < 8 && k < 2000) begin
         @(posedge pclk);
         k++;
         q = (pm_cs === 1'b1) ? 0 : q + 1;
      end
      if (q < 8) n_fail++;
   endtask : xfer_wait

   function automatic logic [31:0] mw(input int iq, st, wd, pt, s, m, h);
      mw = {16'h0000, 1'b0, 2'(iq), 2'(st), 1'(wd), 2'(pt), 2'(s), 4'(m), 2'(h)};
   endfunction : mw

   task start(input logic [31:0] mode, input logic [31:0] d);
      apb(`PPM_OFS_MODE, 1'b1, mode);
      n_ale = 0;
      n_str = 0;
      n_hold = 0;
      ext_u.wq.delete();
      apb(`PPM_OFS_DATA, 1'b1, d);
      xfer_wait();
   endtask : start

   task t_regs;
      apb(`PPM_OFS_MODE, 1'b0, 0);
      check(rd, 0);
      apb(`PPM_OFS_MODE, 1'b1, 32'hffff);
      apb(`PPM_OFS_MODE, 1'b0, 0);
      check(rd & 32'hffff, 32'h7fff);
      apb(12'h100, 1'b0, 0);
      check(rd, 0);
      check(er, 1);
      for (int p = 0; p < 4; p++) begin
         apb(`PPM_OFS_MODE, 1'b1, p << 8);
         @(negedge pclk);
         check({pm_ctl_oe, pm_addr_oe}, {2{p[1]}});
      end
      $display("t_regs done");
   endtask : t_regs

   task automatic t_timing;
      logic [1:0] s[4] = '{2'h3, 2'h1, 2'h0, 2'h3};
      logic [3:0] m[4] = '{4'h0, 4'hf, 4'h2, 4'h1};
      logic [1:0] h[4] = '{2'h3, 2'h2, 2'h0, 2'h3};
      for (int i = 0; i < 4; i++) begin
         start(mw(0, 0, 0, 2, s[i], m[i], h[i]), 32'h5a + i);
         check(n_ale, (m[i] == 0) ? 4 : (s[i] + 1) * 4);
         check(n_str, (m[i] + 1) * 4);
         check(n_hold, (m[i] == 0) ? 4 : (h[i] + 1) * 4);
         check({16'(ext_u.wq.size()), ext_u.wq[0]}, {16'd1, 8'h5a + 8'(i)});
      end
      apb(`PPM_OFS_DATA, 1'b1, 0);
      apb(`PPM_OFS_MODE, 1'b0, 0);
      check(rd[15], 1);
      xfer_wait();
      apb(`PPM_OFS_MODE, 1'b0, 0);
      check(rd[15], 0);
      $display("t_timing done");
   endtask : t_timing

   task t_wide;
      start(mw(0, 0, 1, 3, 0, 1, 0), 32'h1234);
      check({8'(ext_u.wq.size()), ext_u.wq[0], ext_u.wq[1]}, {8'd2, 16'h3412});
      b = 8'hc0 + n_rd;
      apb(`PPM_OFS_DATA, 1'b0, 0);
      xfer_wait();
      apb(`PPM_OFS_DATA, 1'b0, 0);
      check(rd & 32'hffff, {16'h0, b + 8'h01, b});
      xfer_wait();
      $display("t_wide done");
   endtask : t_wide

   task t_step;
      apb(`PPM_OFS_ADDR, 1'b1, 32'h7ff);
      start(mw(0, 1, 0, 2, 0, 0, 0), 0);
      check(pm_addr, 0);
      start(mw(0, 2, 0, 2, 0, 0, 0), 0);
      check(pm_addr, 32'h7ff);
      start(mw(0, 0, 0, 2, 0, 0, 0), 0);
      check(pm_addr, 32'h7ff);
      $display("t_step done");
   endtask : t_step

   task t_irq;
      apb(`PPM_OFS_MASK, 1'b1, 1);
      start(mw(1, 0, 0, 2, 0, 0, 0), 0);
      check(irq, 1);
      apb(`PPM_OFS_STAT, 1'b0, 0);
      check(rd, 1);
      @(posedge pclk);
      check(irq, 0);
      start(mw(0, 0, 0, 2, 0, 0, 0), 0);
      apb(`PPM_OFS_STAT, 1'b0, 0);
      check(rd, 0);
      check(irq, 0);
      apb(`PPM_OFS_MASK, 1'b1, 2);
      apb(`PPM_OFS_ADDR, 1'b1, 5);
      start(mw(2, 0, 0, 2, 0, 0, 0), 0);
      check(irq, 0);
      apb(`PPM_OFS_ADDR, 1'b1, 3);
      start(mw(2, 0, 0, 2, 0, 0, 0), 0);
      check(irq, 1);
      apb(`PPM_OFS_STAT, 1'b0, 0);
      check(rd & 2, 2);
      $display("t_irq done");
   endtask : t_irq

   // Host reads two buffers in buffered slave mode with the auto pointer
   task t_slave;
      apb(`PPM_OFS_BUF, 1'b1, 32'h11);
      apb(`PPM_OFS_BUF + 12'h004, 1'b1, 32'h22);
      apb(`PPM_OFS_MODE, 1'b1, mw(0, 3, 0, 1, 0, 0, 0));
      for (int j = 0; j < 2; j++) begin
         @(posedge pclk);
         {s_cs_n, s_rd_n} <= 2'b00;
         repeat (4) @(posedge pclk);
         check({pm_data_oe, pm_data_o}, {1'b1, 8'h11 * 8'(j + 1)});
         s_rd_n <= 1'b1;
         repeat (4) @(posedge pclk);
         s_cs_n <= 1'b1;
      end
      $display("t_slave done");
   endtask : t_slave

   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : print_verdict

   initial begin
      #100000;
      n_fail++;
      print_verdict();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {n_fail, n_checks} = '0;
      {s_cs_n, s_rd_n} = 2'b11;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_timing();
      t_wide();
      t_step();
      t_irq();
      t_slave();
      print_verdict();
   end
endmodule : test_ppm_port
